// File: rtl/dram_power_state_init_mode_load.v
// Clock-enable power states and mode word loading inside the memory device
//
// How it works
// R1: Controller spaces commands after read with auto precharge by burst and latency.
// R2: Controller refreshes or loads mode only with every bank idle.
// R3: Controller ends a read burst before a write, or stops it.
// R4: Clock enable low twice holds the present low-power state.
// R5: Clock enable rising with no-op exits any low-power state.
// R6: Clock enable falling with no-op, refresh or stop enters a low-power state.
// R7: Controller sends only no-ops during the exit periods.
// R8: After deep sleep exit the controller reruns full initialization.
// R9: Controller toggles the clock at least twice during self refresh exit.
// R10: Initialization may start with clock enable low if raised in time.
// R11: Controller waits 200 us of no-ops after a stable clock.
// R12: Controller precharges all banks, then waits the precharge time.
// R13: Initialization holds two refreshes, each followed by the refresh time.
// R14: Both mode words loaded in either order, each followed by a wait.
// R15: Mode load with bank address zero writes the standard word.
// R16: Standard word kept until reloaded or deep sleep entry.
// R17: Mode reload never touches the stored array contents.
// R18: Controller loads mode only when idle and waits afterwards.
// R19: Controller avoids reserved mode encodings.
// R20: Burst length selectable as 2, 4, 8 or 16 locations.
// R21: Read latency selectable as two or three clocks.
// R22: Mode load with bank address two writes the extended word.
// R23: Uncovered command and clock-enable mixes are flagged illegal.
`include "dram_state_regs.vh"

module dram_power_state_init_mode_load
#(
  parameter ADDR_WIDTH = 13
)
(
  input  wire                  clk,
  input  wire                  reset,
  input  wire                  cke,
  input  wire                  cs_n,
  input  wire                  ras_n,
  input  wire                  cas_n,
  input  wire                  we_n,
  input  wire [1:0]            bank_addr,
  input  wire [ADDR_WIDTH-1:0] addr,
  input  wire                  any_bank_open,
  output reg  [2:0]            power_state,
  output reg                   needs_init,
  output reg                   illegal_cmd,
  output reg  [4:0]            burst_len,
  output reg                   burst_interleaved,
  output reg  [1:0]            read_latency_clocks,
  output reg  [ADDR_WIDTH-1:0] standard_word,
  output reg  [ADDR_WIDTH-1:0] extended_word
);

  // ***************************************************************
  // States
  // ***************************************************************
  localparam ST_NORMAL      = 3'h0;
  localparam ST_ACTIVE_PD   = 3'h1;
  localparam ST_PRECHARGE_PD = 3'h2;
  localparam ST_SELF_REFRESH = 3'h3;
  localparam ST_DEEP_SLEEP  = 3'h4;

  reg        cke_prev;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg        next_illegal;
  reg        clear_words;
  reg        load_en;
  reg        load_sel;
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire       nop = cs_n || (cmd == `CMD_NOP);
  wire [ADDR_WIDTH-1:0] std_q;
  wire [ADDR_WIDTH-1:0] ext_q;

  // Decode burst length code into location count
  function [4:0] decode_burst;
    input [2:0] code;
    begin
      case (code)
        `BURST_CODE_2:  decode_burst = 5'h02;
        `BURST_CODE_4:  decode_burst = 5'h04;
        `BURST_CODE_8:  decode_burst = 5'h08;
        `BURST_CODE_16: decode_burst = 5'h10;
        default:     decode_burst = 5'h00;
      endcase
    end
  endfunction

  // ***************************************************************
  // Power state decisions
  // ***************************************************************
  always @*
  begin
    next_state   = state;
    next_illegal = 1'b0;
    clear_words  = 1'b0;
    load_en      = 1'b0;
    load_sel     = 1'b0;
    case ({cke_prev, cke})
      2'b00:
      begin
        // R4: hold low-power state
        next_state = state;
      end
      2'b01:
      begin
        // R5: exit on no-op
        if (nop)
          next_state = ST_NORMAL;
        else
          next_illegal = 1'b1;
      end
      2'b10:
      begin
        // R6: low-power entry
        if (any_bank_open)
        begin
          if (nop)
            next_state = ST_ACTIVE_PD;
          else
            next_illegal = 1'b1;
        end
        else if (nop)
          next_state = ST_PRECHARGE_PD;
        else if (cmd == `CMD_REFRESH)
          next_state = ST_SELF_REFRESH;
        else if (cmd == `CMD_BURST_STOP)
        begin
          next_state  = ST_DEEP_SLEEP;
          // R16: deep sleep loses mode words
          clear_words = 1'b1;
        end
        else
          next_illegal = 1'b1;
      end
      default:
      begin
        // R23: commands in a low state are illegal when clock enable is high twice; with it held low they are not flagged
        if (state != ST_NORMAL && !nop)
          next_illegal = 1'b1;
        // R15: standard word load
        // R22: extended word load
        if (state == ST_NORMAL && !cs_n && cmd == `CMD_LOADMODE)
        begin
          if (bank_addr == `BA_STANDARD)
            load_en = 1'b1;
          else if (bank_addr == `BA_EXTENDED)
          begin
            load_en  = 1'b1;
            load_sel = 1'b1;
          end
          else
            next_illegal = 1'b1;
        end
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      cke_prev    <= 1'b1;
      state       <= ST_NORMAL;
      power_state <= ST_NORMAL;
      needs_init  <= 1'b0;
      illegal_cmd <= 1'b0;
    end
    else
    begin
      cke_prev    <= cke;
      state       <= next_state;
      power_state <= next_state;
      illegal_cmd <= next_illegal;
      // R8: flag full reinitialization after deep sleep
      if (state == ST_DEEP_SLEEP && next_state == ST_NORMAL)
        needs_init <= 1'b1;
      else if (load_en && state == ST_NORMAL)
        needs_init <= 1'b0;
    end
  end

  // ***************************************************************
  // Mode words
  // ***************************************************************
  // R17: a load changes only the mode words and clears needs_init
  mode_word_store #(.WIDTH(ADDR_WIDTH)) u_store
  (
    .clk           (clk),
    .reset         (reset),
    .clear         (clear_words),
    .write_en      (load_en),
    .write_sel     (load_sel),
    .write_data    (addr),
    .standard_word (std_q),
    .extended_word (ext_q)
  );

  // Outputs re-registered so they come straight from flops
  always @(posedge clk)
  begin
    if (reset)
    begin
      standard_word       <= `MODE_RESET;
      extended_word       <= `EXT_RESET;
      burst_len           <= 5'h00;
      burst_interleaved   <= 1'b0;
      read_latency_clocks <= 2'h0;
    end
    else
    begin
      standard_word     <= std_q;
      extended_word     <= ext_q;
      // R20: burst length decode
      burst_len         <= decode_burst(std_q[`MODE_BURST_MSB:`MODE_BURST_LSB]);
      burst_interleaved <= std_q[`MODE_BT_BIT];
      // R21: latency two or three
      case (std_q[`MODE_LAT_MSB:`MODE_LAT_LSB])
        `LAT_CODE_2: read_latency_clocks <= 2'h2;
        `LAT_CODE_3: read_latency_clocks <= 2'h3;
        default:    read_latency_clocks <= 2'h0;
      endcase
    end
  end

endmodule

// File: rtl/dram_state_regs.vh
// Constants for the power-state and mode-load control block
`ifndef DRAM_STATE_REGS_VH
`define DRAM_STATE_REGS_VH

// Command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP       4'h7
`define CMD_ACTIVE    4'h3
`define CMD_READ      4'h5
`define CMD_WRITE     4'h4
`define CMD_BURST_STOP 4'h6
`define CMD_PRECHARGE 4'h2
`define CMD_REFRESH   4'h1
`define CMD_LOADMODE  4'h0

// Mode word fields and standard word reset value
`define MODE_BURST_LSB 0
`define MODE_BURST_MSB 2
`define MODE_BT_BIT   3
`define MODE_LAT_LSB  4
`define MODE_LAT_MSB  6
`define MODE_OP_LSB   7
`define MODE_RESET    13'h0032

// Burst length and read latency codes
`define BURST_CODE_2  3'h1
`define BURST_CODE_4  3'h2
`define BURST_CODE_8  3'h3
`define BURST_CODE_16 3'h4
`define LAT_CODE_2    3'h2
`define LAT_CODE_3    3'h3

// Bank address selects and extended word reset value
`define BA_STANDARD   2'h0
`define BA_EXTENDED   2'h2
`define EXT_RESET     13'h0000

`endif

// File: rtl/mode_word_store.v
// Holds the standard and extended mode words with registered read data
`include "dram_state_regs.vh"

module mode_word_store
#(
  parameter WIDTH = 13
)
(
  input  wire             clk,
  input  wire             reset,
  input  wire             clear,
  input  wire             write_en,
  input  wire             write_sel,
  input  wire [WIDTH-1:0] write_data,
  output reg  [WIDTH-1:0] standard_word,
  output reg  [WIDTH-1:0] extended_word
);

  // Deep sleep entry wipes both words, as a power loss would
  always @(posedge clk)
  begin
    if (reset || clear)
    begin
      standard_word <= `MODE_RESET;
      extended_word <= `EXT_RESET;
    end
    else if (write_en)
    begin
      if (write_sel)
        extended_word <= write_data;
      else
        standard_word <= write_data;
    end
  end

endmodule

// File: sim/mem_ctrl_model.sv
// Behavioural memory controller driving clock enable and commands
module mem_ctrl_model
(
  input  wire        clk,
  input  wire [3:0]  op,
  input  wire        ck_en,
  input  wire [1:0]  ba,
  input  wire [12:0] a,
  output reg         cke = 1'b1,
  output reg  [3:0]  cmd = 4'hF,
  output reg  [1:0]  bank_addr = 2'h0,
  output reg  [12:0] addr = 13'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Command launch
  // ****************
  // only sequenced commands
  always @(posedge clk)
  begin
    cke <= ck_en;
    cmd <= op;
    bank_addr <= ba;
    // Address only means something with a load, so it is scrambled otherwise
    addr <= (op == 4'h0) ? a : ~addr;
  end
endmodule

// File: sim/dram_state_checker_assertions.sv
// Port-level assertions for the power-state and mode-load block
module dram_state_checker
#(
  parameter ADDR_WIDTH = 13
)
(
  input wire                  clk,
  input wire                  reset,
  input wire                  cke,
  input wire                  cs_n,
  input wire                  ras_n,
  input wire                  cas_n,
  input wire                  we_n,
  input wire [1:0]            bank_addr,
  input wire [ADDR_WIDTH-1:0] addr,
  input wire                  any_bank_open,
  input wire [2:0]            power_state,
  input wire                  illegal_cmd,
  input wire [4:0]            burst_len,
  input wire [1:0]            read_latency_clocks,
  input wire [ADDR_WIDTH-1:0] standard_word,
  input wire [ADDR_WIDTH-1:0] extended_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Helpers
  // ****************
  reg        ckp;
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire       nop = cs_n | (cmd[2:0] == 3'h7);
  wire       up = ckp & cke & (power_state == 3'h0) & (cmd == 4'h0);
  wire       fall = ckp & ~cke & (power_state == 3'h0);
  // Reset counts as a high previous clock enable
  always @(posedge clk)
    ckp <= reset | cke;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_std;
    up && bank_addr == 2'h0;
  endsequence
  a_low_hold: assert property (!ckp && !cke && power_state != 0 |=> $stable(power_state))
    else $error("low state left");
  a_wake_nop: assert property (!ckp && cke && nop && power_state != 0 |=> power_state == 0)
    else $error("no wake");
  a_enter_pd: assert property (fall && nop |=> power_state == ($past(any_bank_open) ? 1 : 2))
    else $error("bad pd entry");
  a_enter_self: assert property (fall && !any_bank_open && cmd == 4'h1 |=> power_state == 3)
    else $error("bad self refresh entry");
  a_enter_deep: assert property (fall && !any_bank_open && cmd == 4'h6 |=> power_state == 4)
    else $error("bad deep entry");
  a_load_std: assert property (s_std |-> ##2 standard_word == $past(addr, 2))
    else $error("standard word");
  a_load_ext: assert property (up && bank_addr == 2'h2 |-> ##2 extended_word == $past(addr, 2))
    else $error("extended word");
  // Decoded fields leave the flops together with the word
  a_burst_len: assert property (s_std |-> ##2 burst_len ==
    ($past(addr[2:0], 2) inside {[1:4]} ? 5'h1 << $past(addr[2:0], 2) : 5'h0))
    else $error("burst length");
  a_latency_set: assert property (s_std |-> ##2 read_latency_clocks ==
    ($past(addr[6:4], 2) inside {2, 3} ? $past(addr[5:4], 2) : 2'h0))
    else $error("latency");
  a_bad_bank: assert property (up && bank_addr[0] |=> illegal_cmd)
    else $error("no illegal flag");
endmodule
bind dram_power_state_init_mode_load dram_state_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.*);

// File: sim/dram_power_state_init_mode_load_tb.sv
// Testbench for the power-state and mode-load block
module dram_power_state_init_mode_load_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  reg         any_bank_open = 1'b0;
  reg         ck_en = 1'b1;
  reg  [3:0]  op = 4'hF;
  reg  [1:0]  ba = 2'h0;
  reg  [12:0] a = 13'h0;
  reg  [12:0] w;
  wire        cke;
  wire [3:0]  cmd;
  wire [1:0]  bank_addr;
  wire [12:0] addr;
  wire [12:0] standard_word;
  wire [12:0] extended_word;
  wire [2:0]  power_state;
  wire [4:0]  burst_len;
  wire [1:0]  read_latency_clocks;
  wire        needs_init;
  wire        illegal_cmd;
  wire        burst_interleaved;
  integer     bad_count = 0;
  integer     checked = 0;
  integer     cycles = 0;
  integer     i;
  integer     e;
  integer     illegal_seen = 0;
  mem_ctrl_model ctrl (.clk(clk), .op(op), .ck_en(ck_en), .ba(ba), .a(a), .cke(cke),
    .cmd(cmd), .bank_addr(bank_addr), .addr(addr));
  dram_power_state_init_mode_load dut (.clk(clk), .reset(reset), .cke(cke), .cs_n(cmd[3]),
    .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .bank_addr(bank_addr), .addr(addr),
    .any_bank_open(any_bank_open), .power_state(power_state), .needs_init(needs_init),
    .illegal_cmd(illegal_cmd), .burst_len(burst_len), .burst_interleaved(burst_interleaved),
    .read_latency_clocks(read_latency_clocks), .standard_word(standard_word),
    .extended_word(extended_word));
  // clock runs free through every exit
  initial
  begin
    forever #10 clk = ~clk;
  end
  // Pulses last one cycle, so they are counted
  always @(posedge clk)
    if (illegal_cmd === 1'b1)
      illegal_seen <= illegal_seen + 1;
  // ****************
  // Tasks
  // ****************
  task chk(input [12:0] seen, input [12:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // One command, then n idle edges at the same clock enable
  task go(input [3:0] o, input k, input [1:0] b, input [12:0] v, input integer n);
  begin
    op <= o;
    ck_en <= k;
    ba <= b;
    a <= v;
    @(posedge clk);
    op <= 4'h7;
    repeat (n) @(posedge clk);
  end
  endtask
  task wrap_up;
  begin
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 500)
    begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    go(4'h7, 1, 0, 0, 3);
    chk(standard_word, 13'h0032);
    chk(burst_len, 5'h4);
    chk(read_latency_clocks, 2'h3);
    chk(burst_interleaved, 1'b0);
    chk(needs_init, 1'b0);
    // idle, spaced loads of legal codes
    for (i = 1; i < 5; i = i + 1)
    begin
      w = {6'h0, 3'h2 + i[0], i[0], i[2:0]};
      go(4'h0, 1, 2'h0, w, 5);
      chk(standard_word, w);
      chk(burst_len, 5'h1 << i);
      chk(read_latency_clocks, 2'h2 + i[0]);
      chk(burst_interleaved, i[0]);
    end
    go(4'h0, 1, 2'h2, 13'h00A5, 5);
    chk(extended_word, 13'h00A5);
    go(4'h0, 1, 2'h1, 13'h1FFF, 5);
    chk(extended_word, 13'h00A5);
    chk(standard_word, w);
    chk(illegal_seen, 1);
    // Power-down, active power-down, self refresh, deep sleep
    for (i = 0; i < 4; i = i + 1)
    begin
      e = (i == 0) ? 2 : ((i == 1) ? 1 : i + 1);
      any_bank_open <= (i == 1);
      go((i < 2) ? 4'h7 : ((i == 2) ? 4'h1 : 4'h6), 0, 0, 0, 3);
      chk(power_state, e[2:0]);
      go(4'h5, 0, 0, 0, 2);
      chk(power_state, e[2:0]);
      go(4'hF, 1, 0, 0, 3);
      chk(power_state, 3'h0);
    end
    chk(standard_word, 13'h0032);
    chk(extended_word, 13'h0000);
    chk(needs_init, 1'b1);
    go(4'h0, 1, 2'h0, 13'h0032, 5);
    go(4'h0, 1, 2'h2, 13'h0000, 5);
    chk(needs_init, 1'b0);
    // Read on a clock enable fall is refused
    go(4'h5, 0, 0, 0, 2);
    chk(power_state, 3'h0);
    go(4'hF, 1, 0, 0, 3);
    chk(illegal_seen, 2);
    wrap_up;
  end
endmodule
